// ---- rtl/uart_ctrl_regs.vh ----
`ifndef UART_CTRL_REGS_VH
`define UART_CTRL_REGS_VH

// ============================================================
// Register offsets
`define ADDR_QUEUE_CONTROL   3'h2
`define ADDR_LINE_FORMAT     3'h3
`define ADDR_MODE_CONFIG     3'h4
`define ADDR_QUEUE_STATUS    3'h5
`define ADDR_LINE_SHADOW     3'h6

// ============================================================
// Queue control fields
`define QC_ENABLE            0
`define QC_RX_RESET          1
`define QC_TX_RESET          2
`define QC_TX_TH_LO          4
`define QC_TX_TH_HI          5
`define QC_RX_TH_LO          6
`define QC_RX_TH_HI          7

// ============================================================
// Line format fields
`define LF_LEN_LO            0
`define LF_LEN_HI            1
`define LF_STOP              2
`define LF_PARITY_ON         3
`define LF_EVEN              4
`define LF_STICK             5
`define LF_BREAK             6
`define LF_BANK_SWITCH       7

// ============================================================
// Mode config fields and mode codes
`define MC_MODE_LO           0
`define MC_MODE_HI           2
`define MC_EXTENDED          3
`define MC_DEEP              4
`define MC_MODULATE          5
`define MODE_SERIAL          3'h0
`define MODE_DIRECTED_IR     3'h2
`define MODE_SERIAL_IR       3'h3
`define MODE_REMOTE_IR       3'h6

// ============================================================
// Reset values and bank codes
`define LINE_FORMAT_RESET    8'h00
`define BANK_SELECT_RESET    8'h00
`define QUEUE_CONTROL_RESET  8'h00
`define MODE_CONFIG_RESET    8'h00
`define BANK_RESERVED        3'h7
`define BANK_INVALID         4'hF
`define QC_WRITE_MASK        8'hF7
`define CHAR_BITS_BASE       4'h5
`define CHAR_BITS_FULL       4'h8

// ============================================================
// Thresholds, 16-deep and 32-deep
`define TX_TH16_0            6'h01
`define TX_TH16_1            6'h03
`define TX_TH16_2            6'h09
`define TX_TH16_3            6'h0D
`define TX_TH32_0            6'h01
`define TX_TH32_1            6'h07
`define TX_TH32_2            6'h11
`define TX_TH32_3            6'h19
`define RX_TH16_0            6'h01
`define RX_TH16_1            6'h04
`define RX_TH16_2            6'h08
`define RX_TH16_3            6'h0E
`define RX_TH32_0            6'h01
`define RX_TH32_1            6'h08
`define RX_TH32_2            6'h10
`define RX_TH32_3            6'h1A

// ============================================================
// Pulse train half period less one, in clocks
`define IR_PULSE_HALF        4'h3

`endif

// ---- rtl/bank_decoder.v ----
`timescale 1ns/1ns
`include "uart_ctrl_regs.vh"

// Decodes a bank select byte into a bank number
module bank_decoder (
    input  wire [7:0] code,
    output reg  [3:0] bank,
    output reg        writes_format
);

    // ============================================================
    // Decode
    // bank decoding table
    always @* begin
        bank          = `BANK_INVALID;
        writes_format = 1'b0;
        if (code[7] == 1'b0) begin
            bank          = 4'h0;
            writes_format = 1'b1;
        end else if (code[6] == 1'b0 || code[1] == 1'b1 || code[0] == 1'b1) begin
            bank          = 4'h1;
            writes_format = 1'b1;
        end else if (code[5] == 1'b1 && code[4:2] < 3'h6 && code[4:2] != 3'h2
                     && code[4:2] != 3'h3) begin
            bank = {1'b0, code[4:2] == 3'h0 ? 3'h2 : code[4:2] == 3'h1 ? 3'h3 :
                    code[4:2] == 3'h4 ? 3'h6 : 3'h7};
        end else if (code[5] == 1'b1 && (code[4:2] == 3'h2 || code[4:2] == 3'h3)) begin
            bank = {1'b0, code[2] ? 3'h5 : 3'h4};
        end
    end

endmodule

// ---- rtl/uart_fifo_line_bank_ctrl.v ----
`timescale 1ns/1ns
`include "uart_ctrl_regs.vh"

module uart_fifo_line_bank_ctrl #(
    parameter DEPTH_W = 6
) (
    input  wire               clk,
    input  wire               rst,
    input  wire [2:0]         addr,
    input  wire [7:0]         wdata,
    input  wire               wr,
    input  wire               rd,
    output reg  [7:0]         rdata,
    input  wire [DEPTH_W-1:0] tx_level,
    input  wire [DEPTH_W-1:0] rx_level,
    input  wire               tx_serial,
    input  wire               tx_ir,
    input  wire               transmitter_idle_flag,
    output reg                queues_enabled,
    output reg                rx_queue_flush,
    output reg                tx_queue_flush,
    output reg                receiver_soft_reset,
    output reg                transmitter_soft_reset,
    output reg                status_error_clear,
    output reg                tx_level_event,
    output reg                rx_level_event,
    output reg  [3:0]         char_bits,
    output reg                stop_extra,
    output reg                stop_half,
    output reg                parity_on,
    output reg                parity_value_fixed,
    output reg                parity_fixed_level,
    output reg                parity_even,
    output reg  [3:0]         active_bank,
    output reg                serial_output_pin,
    output reg                infrared_output_pin
);

    // ============================================================
    // Stored state
    reg  [7:0] queue_control;
    reg  [7:0] line_format;
    reg  [7:0] bank_select;
    reg  [7:0] mode_config;
    reg  [3:0] pulse_count;
    reg        pulse_level;
    reg  [7:0] next_rdata;

    wire [3:0] wr_bank;
    wire       wr_format;
    wire [3:0] cur_bank;

    wire [2:0] mode      = mode_config[`MC_MODE_HI:`MC_MODE_LO];
    wire       extended  = mode_config[`MC_EXTENDED];
    wire       deep      = mode_config[`MC_DEEP];
    wire       modulate  = mode_config[`MC_MODULATE];
    wire       remote_ir = (mode == `MODE_REMOTE_IR);
    wire       brk       = line_format[`LF_BREAK] & ~remote_ir;
    wire       wr_qc     = wr && (addr == `ADDR_QUEUE_CONTROL);
    wire       wr_lf     = wr && (addr == `ADDR_LINE_FORMAT);
    wire       wr_mc     = wr && (addr == `ADDR_MODE_CONFIG);
    wire       queues_on = queue_control[`QC_ENABLE] | remote_ir;
    wire [1:0] len_sel   = line_format[`LF_LEN_HI:`LF_LEN_LO];

    // Level operands widened to the threshold width, and current limits
    wire [5:0] tx_level_x = {{(6-DEPTH_W){1'b0}}, tx_level};
    wire [5:0] rx_level_x = {{(6-DEPTH_W){1'b0}}, rx_level};
    wire [5:0] tx_limit;
    wire [5:0] rx_limit;

    // ============================================================
    // Threshold decode
    function [5:0] tx_threshold;
        input [1:0] sel;
        input       is_deep;
        begin
            case (sel)
                2'h0:    tx_threshold = is_deep ? `TX_TH32_0 : `TX_TH16_0;
                2'h1:    tx_threshold = is_deep ? `TX_TH32_1 : `TX_TH16_1;
                2'h2:    tx_threshold = is_deep ? `TX_TH32_2 : `TX_TH16_2;
                default: tx_threshold = is_deep ? `TX_TH32_3 : `TX_TH16_3;
            endcase
        end
    endfunction

    function [5:0] rx_threshold;
        input [1:0] sel;
        input       is_deep;
        begin
            case (sel)
                2'h0:    rx_threshold = is_deep ? `RX_TH32_0 : `RX_TH16_0;
                2'h1:    rx_threshold = is_deep ? `RX_TH32_1 : `RX_TH16_1;
                2'h2:    rx_threshold = is_deep ? `RX_TH32_2 : `RX_TH16_2;
                default: rx_threshold = is_deep ? `RX_TH32_3 : `RX_TH16_3;
            endcase
        end
    endfunction

    // Limits for the thresholds and depth in force
    assign tx_limit = tx_threshold(queue_control[`QC_TX_TH_HI:`QC_TX_TH_LO], deep);
    assign rx_limit = rx_threshold(queue_control[`QC_RX_TH_HI:`QC_RX_TH_LO], deep);

    // ============================================================
    // Bank decoders for write data and stored value
    bank_decoder u_wr_dec (
        .code          (wdata),
        .bank          (wr_bank),
        .writes_format (wr_format)
    );

    bank_decoder u_cur_dec (
        .code          (bank_select),
        .bank          (cur_bank),
        .writes_format ()
    );

    // ============================================================
    // Register writes
    // Soft reset bits clear on the next clock unless rewritten, so a
    // write that sets them again in that cycle wins over the clear.
    always @(posedge clk) begin
        if (rst) begin
            queue_control <= `QUEUE_CONTROL_RESET;
            line_format   <= `LINE_FORMAT_RESET;
            bank_select   <= `BANK_SELECT_RESET;
            mode_config   <= `MODE_CONFIG_RESET;
        end else begin
            queue_control[`QC_RX_RESET] <= 1'b0;
            queue_control[`QC_TX_RESET] <= 1'b0;
            if (wr_qc) begin
                queue_control <= wdata & `QC_WRITE_MASK;
            end
            if (wr_lf) begin
                bank_select <= wdata;
                if (wr_format) begin
                    line_format <= wdata;
                end
            end
            if (wr_mc) begin
                mode_config <= wdata;
            end
        end
    end

    // ============================================================
    // Read data, one cycle after the strobe
    // Registered and zeroed otherwise, so read data stands for exactly
    // the one cycle after the strobe.
    always @* begin
        next_rdata = 8'h00;
        if (addr == `ADDR_QUEUE_CONTROL) begin
            next_rdata = 8'h00;
        end else if (addr == `ADDR_LINE_FORMAT) begin
            next_rdata = bank_select;
        end else if (addr == `ADDR_MODE_CONFIG) begin
            next_rdata = mode_config;
        end else if (addr == `ADDR_QUEUE_STATUS) begin
            next_rdata = {5'h00, transmitter_idle_flag, rx_level_event, tx_level_event};
        end else if (addr == `ADDR_LINE_SHADOW) begin
            next_rdata = line_format;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? next_rdata : 8'h00;
        end
    end

    // ============================================================
    // Queue enable and flush outputs
    // Flush holds while the queues are disabled and pulses for one
    // clock with the soft reset bit for its own queue.
    always @(posedge clk) begin
        if (rst) begin
            queues_enabled <= 1'b0;
            rx_queue_flush <= 1'b1;
            tx_queue_flush <= 1'b1;
        end else begin
            queues_enabled <= queues_on;
            rx_queue_flush <= ~queues_on | queue_control[`QC_RX_RESET];
            tx_queue_flush <= ~queues_on | queue_control[`QC_TX_RESET];
        end
    end

    // ============================================================
    // Soft reset pulses
    always @(posedge clk) begin
        if (rst) begin
            receiver_soft_reset    <= 1'b1;
            transmitter_soft_reset <= 1'b1;
            status_error_clear     <= 1'b1;
        end else begin
            receiver_soft_reset    <= queue_control[`QC_RX_RESET];
            status_error_clear     <= queue_control[`QC_RX_RESET];
            transmitter_soft_reset <= queue_control[`QC_TX_RESET];
        end
    end

    // ============================================================
    // Queue level events
    // Limits follow the depth in force now, so a depth change acts on
    // the next clock without rewriting the threshold fields.
    always @(posedge clk) begin
        if (rst) begin
            tx_level_event <= 1'b0;
            rx_level_event <= 1'b0;
        end else begin
            tx_level_event <= extended && (tx_level_x < tx_limit);
            rx_level_event <= (rx_level_x >= rx_limit);
        end
    end

    // ============================================================
    // Active bank output
    always @(posedge clk) begin
        if (rst) begin
            active_bank <= 4'h0;
        end else begin
            active_bank <= cur_bank;
        end
    end

    // ============================================================
    // Character length and stop bits
    // Remote-control infrared has no character framing, so the outputs
    // fall back to eight bits with one stop bit there.
    always @(posedge clk) begin
        if (rst) begin
            char_bits  <= `CHAR_BITS_BASE;
            stop_extra <= 1'b0;
            stop_half  <= 1'b0;
        end else begin
            char_bits <= remote_ir ? `CHAR_BITS_FULL :
                         `CHAR_BITS_BASE + {2'h0, len_sel};
            stop_extra <= ~remote_ir & line_format[`LF_STOP];
            stop_half  <= ~remote_ir & line_format[`LF_STOP] & (len_sel == 2'h0);
        end
    end

    // ============================================================
    // Parity selection
    always @(posedge clk) begin
        if (rst) begin
            parity_on          <= 1'b0;
            parity_value_fixed <= 1'b0;
            parity_fixed_level <= 1'b0;
            parity_even        <= 1'b0;
        end else begin
            parity_on          <= ~remote_ir & line_format[`LF_PARITY_ON];
            parity_value_fixed <= line_format[`LF_STICK];
            // Stick level is one while even select is clear
            parity_fixed_level <= ~line_format[`LF_EVEN];
            parity_even        <= line_format[`LF_EVEN];
        end
    end

    // ============================================================
    // Infrared pulse train for break
    // Free running, so a break starts on whatever phase it finds.
    always @(posedge clk) begin
        if (rst) begin
            pulse_count <= 4'h0;
            pulse_level <= 1'b0;
        end else if (pulse_count == `IR_PULSE_HALF) begin
            pulse_count <= 4'h0;
            pulse_level <= ~pulse_level;
        end else begin
            pulse_count <= pulse_count + 4'h1;
        end
    end

    // ============================================================
    // Transmit front end with break
    // Break overrides only the pins; the transmitter keeps running so
    // that it can still time the break length.
    always @(posedge clk) begin
        if (rst) begin
            serial_output_pin   <= 1'b1;
            infrared_output_pin <= 1'b0;
        end else begin
            if (brk && mode == `MODE_SERIAL) begin
                serial_output_pin <= 1'b0;
            end else begin
                serial_output_pin <= tx_serial;
            end
            if (brk && mode == `MODE_DIRECTED_IR && !modulate) begin
                infrared_output_pin <= 1'b1;
            end else if (brk && (mode == `MODE_SERIAL_IR || mode == `MODE_DIRECTED_IR)) begin
                infrared_output_pin <= pulse_level;
            end else begin
                infrared_output_pin <= tx_ir;
            end
        end
    end

endmodule

// ---- sim/uart_fifo_line_bank_ctrl_props.sv ----
`timescale 1ns/1ns
// ============================================================
// Port checker for the queue, format and bank control block
module ctrl_props (
    input wire       clk,
    input wire       rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       queues_enabled,
    input wire       rx_queue_flush,
    input wire       tx_queue_flush,
    input wire       receiver_soft_reset,
    input wire       transmitter_soft_reset,
    input wire       status_error_clear,
    input wire [3:0] char_bits,
    input wire [3:0] active_bank
);
    // Decoded write strobes and the length code on the bus
    wire [3:0] len_code = {2'h0, wdata[1:0]};
    wire       qc_wr    = wr && addr == 3'h2;
    wire       lf_wr    = wr && addr == 3'h3;
    reg  [2:0] mode_seen;
    // Mode code last written at offset 4, for the format checks
    always @(posedge clk) begin
        if (rst)
            mode_seen <= 3'h0;
        else if (wr && addr == 3'h4)
            mode_seen <= wdata[2:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_rx_soft_reset: assert property (
        qc_wr && wdata[1] |-> ##2 receiver_soft_reset && status_error_clear)
        else $error("receiver reset pulse missing");
    chk_tx_soft_reset: assert property (
        qc_wr && wdata[2] |-> ##2 transmitter_soft_reset && tx_queue_flush)
        else $error("transmitter reset pulse missing");
    chk_reset_self_clear: assert property (
        qc_wr && wdata[1] ##1 !(qc_wr && wdata[1]) |-> ##2 !receiver_soft_reset)
        else $error("receiver reset did not clear itself");
    chk_qc_read_zero: assert property (
        rd && addr == 3'h2 |=> rdata == 8'h00)
        else $error("queue control read back");
    chk_bank_readback: assert property (
        lf_wr ##1 !lf_wr ##1 rd && addr == 3'h3 |=> rdata == $past(wdata, 3))
        else $error("offset 3 read is not the bank select value");
    chk_format_length: assert property (
        lf_wr && !wdata[7] && mode_seen != 3'h6 |-> ##2 char_bits == 4'h5 + $past(len_code, 2))
        else $error("character length wrong");
    chk_bank_zero: assert property (
        lf_wr && !wdata[7] |-> ##2 active_bank == 4'h0)
        else $error("bit 7 clear did not select bank 0");
    chk_flush_disabled: assert property (
        !queues_enabled |-> rx_queue_flush && tx_queue_flush)
        else $error("queues disabled but not flushed");
    chk_format_hold: assert property (
        lf_wr && wdata[7:5] == 3'h7 && wdata[1:0] == 2'h0 |-> ##2 $stable(char_bits))
        else $error("bank switch changed the format");
endmodule

bind uart_fifo_line_bank_ctrl ctrl_props chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .queues_enabled, .rx_queue_flush, .tx_queue_flush, .receiver_soft_reset,
    .transmitter_soft_reset, .status_error_clear, .char_bits, .active_bank);

// ---- sim/line_monitor.sv ----
`timescale 1ns/1ns
// ============================================================
// Far-end line watcher: low run on the wire, toggles on infrared
module line_monitor (
    input  wire       clk,
    input  wire       serial_output_pin,
    input  wire       infrared_output_pin,
    output reg  [7:0] low_run = 8'h00,
    output reg  [7:0] ir_edges = 8'h00
);
    reg ir_q = 1'b0;
    // Saturating low count, free-running toggle count
    always @(posedge clk) begin
        ir_q <= infrared_output_pin;
        if (serial_output_pin)
            low_run <= 8'h00;
        else if (low_run != 8'hFF)
            low_run <= low_run + 8'h01;
        if (ir_q != infrared_output_pin)
            ir_edges <= ir_edges + 8'h01;
    end
endmodule

// ---- sim/uart_fifo_line_bank_ctrl_tb.sv ----
`timescale 1ns/1ns
// ============================================================
// Bench for the queue, format and bank control block
module uart_fifo_line_bank_ctrl_tb;
    reg        clk, rst, wr, rd, tx_serial, transmitter_idle_flag, tx_ir;
    reg  [2:0] addr;
    reg  [7:0] wdata, v;
    reg  [5:0] tx_level, rx_level;
    wire [7:0] rdata, low_run, ir_edges;
    wire [3:0] char_bits, active_bank;
    wire       queues_enabled, rx_queue_flush, tx_queue_flush, receiver_soft_reset;
    wire       transmitter_soft_reset, status_error_clear, tx_level_event, rx_level_event;
    wire       stop_half, parity_on, parity_value_fixed, parity_fixed_level, parity_even;
    wire       serial_output_pin, infrared_output_pin, stop_extra;
    integer    err_count, checked, i, j, n;
    // Thresholds, 16-deep in the low half, 32-deep in the high half
    localparam [47:0] RTH = {6'h1A, 6'h10, 6'h08, 6'h01, 6'h0E, 6'h08, 6'h04, 6'h01};
    localparam [47:0] TTH = {6'h19, 6'h11, 6'h07, 6'h01, 6'h0D, 6'h09, 6'h03, 6'h01};

    uart_fifo_line_bank_ctrl #(.DEPTH_W(6)) uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .tx_level, .rx_level, .tx_serial, .tx_ir, .transmitter_idle_flag,
        .queues_enabled, .rx_queue_flush, .tx_queue_flush, .receiver_soft_reset,
        .transmitter_soft_reset, .status_error_clear, .tx_level_event, .rx_level_event,
        .char_bits, .stop_extra, .stop_half, .parity_on, .parity_value_fixed,
        .parity_fixed_level, .parity_even, .active_bank, .serial_output_pin,
        .infrared_output_pin);
    line_monitor far_end (.clk, .serial_output_pin, .infrared_output_pin, .low_run, .ir_edges);

    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ============================================================
    // Access and comparison tasks
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task step(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr_reg(input [2:0] a, input [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task rd_reg(input [2:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    task lvl(input [5:0] r, input [5:0] t);
        @(posedge clk);
        rx_level <= r;
        tx_level <= t;
        step(2);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Poll transmitter idle in status, bounded
    task wait_idle;
        n = 0;
        rd_reg(3'h5);
        while (v[2] !== 1'b1 && n < 40) begin
            rd_reg(3'h5);
            n = n + 1;
        end
        if (v[2] !== 1'b1) begin
            err_count = err_count + 1;
            wrap_up;
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        {rst, tx_serial, transmitter_idle_flag, tx_ir} = 4'hE;
        {wr, rd, addr, wdata, tx_level, rx_level} = 25'h0;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step(2);
        check("len", char_bits, 8'h05);
        rd_reg(3'h3);
        check("bsel", v, 8'h00);
        rd_reg(3'h7);
        check("unmapped", v, 8'h00);
        wr_reg(3'h2, 8'h09);
        step(1);
        check("qen", queues_enabled, 8'h01);
        check("rxfl", rx_queue_flush, 8'h00);
        rd_reg(3'h2);
        check("qc_rd", v, 8'h00);
        wr_reg(3'h2, 8'h07);
        step(1);
        check("receiver_soft_reset", receiver_soft_reset, 8'h01);
        check("transmitter_soft_reset", transmitter_soft_reset, 8'h01);
        check("errclr", status_error_clear, 8'h01);
        step(1);
        check("srs", {receiver_soft_reset, transmitter_soft_reset}, 8'h00);
        wr_reg(3'h2, 8'h00);
        step(1);
        check("qen", queues_enabled, 8'h00);
        wr_reg(3'h4, 8'h06);
        wr_reg(3'h2, 8'h00);
        step(1);
        check("qen_rc", queues_enabled, 8'h01);
        for (j = 0; j < 2; j = j + 1)
            for (i = 0; i < 4; i = i + 1) begin
                wr_reg(3'h4, {3'h0, j[0], 4'h8});
                wr_reg(3'h2, {i[1:0], i[1:0], 4'h1});
                lvl(RTH[(j*4+i)*6 +: 6] - 6'h01, TTH[(j*4+i)*6 +: 6]);
                check("ev_lo", {rx_level_event, tx_level_event}, 8'h00);
                lvl(RTH[(j*4+i)*6 +: 6], TTH[(j*4+i)*6 +: 6] - 6'h01);
                check("ev_hi", {rx_level_event, tx_level_event}, 8'h03);
            end
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h2, 8'h31);
        lvl(6'h00, 6'h02);
        v = {7'h00, tx_level_event};
        wr_reg(3'h2, 8'h01);
        step(2);
        check("txev_std", tx_level_event, v);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(3'h3, {2'h0, i[1], i[0], 1'b1, !i[0], i[1:0]});
            step(1);
            check("len", char_bits, 8'h05 + i[1:0]);
            check("half", stop_half, {7'h00, i == 0});
            check("stop", stop_extra, {7'h00, !i[0]});
            check("par", {parity_on, parity_value_fixed}, {6'h00, 1'b1, i[1]});
            if (i[1])
                check("lvl", parity_fixed_level, !i[0]);
            else
                check("even", parity_even, i[0]);
            rd_reg(3'h3);
            check("bsel", v, {2'h0, i[1], i[0], 1'b1, !i[0], i[1:0]});
        end
        wr_reg(3'h3, 8'h03);
        step(1);
        check("par", parity_on, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            wr_reg(3'h3, 8'hE0 + 8'h04 * i[7:0]);
            step(1);
            check("bank", active_bank, 8'h02 + i[7:0]);
            check("len", char_bits, 8'h08);
        end
        rd_reg(3'h3);
        check("bsel", v, 8'hF4);
        wr_reg(3'h3, 8'hC0);
        step(1);
        check("bank", active_bank, 8'h0F);
        wr_reg(3'h3, 8'h82);
        step(1);
        check("bank1", {active_bank, char_bits}, 8'h17);
        transmitter_idle_flag <= 1'b0;
        fork
            wait_idle;
            #700 transmitter_idle_flag <= 1'b1;
        join
        wr_reg(3'h3, 8'h43);
        step(20);
        check("brk", {low_run > 8'h10, serial_output_pin}, 8'h02);
        wait_idle;
        wr_reg(3'h3, 8'h03);
        step(2);
        check("serial_output_pin", serial_output_pin, 8'h01);
        for (i = 0; i < 2; i = i + 1) begin
            wr_reg(3'h4, i ? 8'h22 : 8'h03);
            wr_reg(3'h3, 8'h43);
            v = ir_edges;
            step(40);
            check("infrared_output_pin", {7'h00, ir_edges - v > 8'h05}, 8'h01);
        end
        wr_reg(3'h4, 8'h02);
        step(2);
        check("infrared_output_pin_hi", infrared_output_pin, 8'h01);
        rd_reg(3'h4);
        check("mode", v, 8'h02);
        rd_reg(3'h6);
        check("shadow", v, 8'h43);
        // Second reset in mid-run, then pins follow the front end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst       <= 1'b0;
        tx_ir     <= 1'b1;
        tx_serial <= 1'b0;
        step(2);
        check("len_rst", char_bits, 8'h05);
        check("pins", {serial_output_pin, infrared_output_pin}, 8'h01);
        rd_reg(3'h6);
        check("shadow_rst", v, 8'h00);
        wrap_up;
    end
endmodule
